// ### logic/rcff_consts.vh
`ifndef RCFF_CONSTS_VH
`define RCFF_CONSTS_VH

// ----------------------------------------
// filter bank geometry
// ----------------------------------------
`define RCFF_NUM_ORD      8
`define RCFF_NUM_ALL      11
`define RCFF_PAT_BITS     512
`define RCFF_WIN_BYTES    7'h40
`define RCFF_WORDS        16

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define RCFF_ADDR_CTRL    8'h00
`define RCFF_ADDR_ENABLE  8'h04
`define RCFF_ADDR_STATUS  8'h08
`define RCFF_ADDR_PASSCNT 8'h0c
`define RCFF_ADDR_DROPCNT 8'h10
`define RCFF_ADDR_PAT_LO  8'h40
`define RCFF_ADDR_MSK_LO  8'h80
`define RCFF_ADDR_MSK_HI  8'hbc

// ----------------------------------------
// control fields
// ----------------------------------------
`define RCFF_CTRL_PROMISC 31
`define RCFF_CTRL_BANK    8
`define RCFF_CTRL_MASKW   32'h8000_0107
`define RCFF_AV_IGNORED   2'h3
`define RCFF_AV_BASE      4'h8

// ----------------------------------------
// reset values
// ----------------------------------------
`define RCFF_CTRL_RST     32'h8000_0000
`define RCFF_EN_RST       11'h700
`define RCFF_ORD_PAT_RST  {464'h0, 48'hffff_ffff_ffff}
`define RCFF_ORD_MSK_RST  {464'h0, 48'hffff_ffff_ffff}
`define RCFF_PTP_PAT_RST  {400'h0, 16'hf788, 96'h0}
`define RCFF_PTP_MSK_RST  {400'h0, 16'hffff, 96'h0}
`define RCFF_SRA_PAT_RST  {384'h0, 32'h0260_0081, 96'h0}
`define RCFF_SRB_PAT_RST  {384'h0, 32'h0240_0081, 96'h0}
`define RCFF_SR_MSK_RST   {384'h0, 32'hffff_ffff, 96'h0}

`endif

// ### logic/rcff_match.v
`timescale 1ns/1ps
`default_nettype none
`include "rcff_consts.vh"

module rcff_match (
    input  wire         clk,
    input  wire         rst_n,
    input  wire [511:0] pattern,
    input  wire [511:0] mask,
    input  wire         enable,
    input  wire [6:0]   byte_idx,
    input  wire [7:0]   data,
    input  wire         valid,
    input  wire         last,
    output wire         hit
);

    // ----------------------------------------
    // per-byte masked compare
    // ----------------------------------------
    reg          ok_q;
    wire         in_win   = byte_idx < `RCFF_WIN_BYTES;
    wire [8:0]   bit_base = {byte_idx[5:0], 3'b000};
    wire [7:0]   pat_b    = pattern[bit_base +: 8];
    wire [7:0]   msk_b    = mask[bit_base +: 8];
    wire [511:0] rest     = mask >> bit_base;
    wire         byte_ok  = ~in_win | (((data ^ pat_b) & msk_b) == 8'h00);
    // a short frame fails if any masked byte was never received
    wire         tail_ok  = ~in_win | (rest[511:8] == 504'h0);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ok_q <= 1'b1;
        end else if (valid) begin
            if (last) begin
                ok_q <= 1'b1;
            end else begin
                ok_q <= ok_q & byte_ok;
            end
        end
    end

    // disabled filter never hits
    assign hit = enable & ok_q & byte_ok & tail_ok & valid & last;

endmodule // rcff_match

`default_nettype wire

// ### logic/rcff_top.v
// Behaviour
// - promiscuous on: every good frame is marked good whatever the filters say.
// - promiscuous off: good only with a destination address hit or enabled filter hit.
// - masks let a filter isolate any fields within the first 64 bytes.
// - each filter has its own enable; a disabled filter never matches.
// - ordinary filters reset to ones in low 48 pattern and mask bits.
// - verdict bus has one bit per ordinary filter plus a top catch-all bit.
// - a per-filter verdict bit is set when that filter did not match.
// - catch-all bit is set whenever any ordinary filter matched.
// - promiscuous mode does not change the verdict bits.
// - control bit 8 steers per-filter accesses to the stream class bank.
// - in that bank control bits 1:0 pick the filter; value 3 is ignored.
// - bank index 1 is class A filter, index 2 is class B filter.
// - class A and class B matches are ORed into the AV pass flag.
// - class filters reset to type 0x0081, tag info 0x0260 A and 0x0240 B.
// - bank filters reset to timing and AV class values; software may rewrite.
// - mask one compares the pattern bit; mask zero makes it a don't care.
// - pattern bit 0 lines up with the first received bit of the frame.
// - eight ordinary filters plus three stream class bank filters.
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "rcff_consts.vh"

module rcff_top (
    input  wire        CORE_CLK,
    input  wire        RESETN,
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [7:0]  PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output wire        PREADY,
    output reg         PSLVERR,
    input  wire [7:0]  RX_DATA,
    input  wire        RX_VALID,
    input  wire        RX_LAST,
    input  wire        RX_GOOD,
    input  wire        RX_DA_MATCH,
    output reg  [7:0]  M_DATA,
    output reg         M_VALID,
    output reg         M_LAST,
    output reg         M_GOOD,
    output reg  [8:0]  FILTER_TUSER,
    output reg         AV_PASS
);

    // ----------------------------------------
    // register state
    // ----------------------------------------
    reg  [31:0]  ctrl_q;
    reg  [10:0]  enable_q;
    reg  [511:0] pat_q [0:10];
    reg  [511:0] msk_q [0:10];
    reg  [6:0]   byte_cnt_q;
    reg  [15:0]  pass_cnt_q;
    reg  [15:0]  drop_cnt_q;
    reg  [10:0]  last_hit_q;
    integer      k;

    wire         promisc  = ctrl_q[`RCFF_CTRL_PROMISC];
    wire         bank_sel = ctrl_q[`RCFF_CTRL_BANK];

    // ----------------------------------------
    // filter selection for window accesses
    // ----------------------------------------
    reg  [3:0]   sel_idx;
    reg          sel_ok;

    always @* begin
        if (bank_sel) begin
            sel_idx = `RCFF_AV_BASE + {2'b00, ctrl_q[1:0]};
            sel_ok  = (ctrl_q[1:0] != `RCFF_AV_IGNORED);
        end else begin
            // later writes always go to the filter that control names
            sel_idx = {1'b0, ctrl_q[2:0]};
            sel_ok  = 1'b1;
        end
    end

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    wire         acc      = PSEL & PENABLE;
    wire         wr       = acc & PWRITE;
    wire         in_pat   = (PADDR >= `RCFF_ADDR_PAT_LO) && (PADDR < `RCFF_ADDR_MSK_LO);
    wire         in_msk   = (PADDR >= `RCFF_ADDR_MSK_LO) && (PADDR <= `RCFF_ADDR_MSK_HI);
    wire [3:0]   word_idx = PADDR[5:2];
    wire [8:0]   word_bit = {word_idx, 5'b00000};
    wire         aligned  = (PADDR[1:0] == 2'b00);

    reg          mapped;
    reg  [31:0]  rd_mux;

    always @* begin
        mapped = aligned;
        rd_mux = 32'h0;
        if (in_pat) begin
            rd_mux = sel_ok ? pat_q[sel_idx][word_bit +: 32] : 32'h0;
        end else if (in_msk) begin
            rd_mux = sel_ok ? msk_q[sel_idx][word_bit +: 32] : 32'h0;
        end else begin
            case (PADDR)
                `RCFF_ADDR_CTRL: begin
                    rd_mux = ctrl_q;
                end
                `RCFF_ADDR_ENABLE: begin
                    rd_mux = {21'h0, enable_q};
                end
                `RCFF_ADDR_STATUS: begin
                    rd_mux = {5'h0, last_hit_q, 5'h0, AV_PASS, M_GOOD, FILTER_TUSER};
                end
                `RCFF_ADDR_PASSCNT: begin
                    rd_mux = {16'h0, pass_cnt_q};
                end
                `RCFF_ADDR_DROPCNT: begin
                    rd_mux = {16'h0, drop_cnt_q};
                end
                default: begin
                    mapped = 1'b0;
                end
            endcase
        end
    end

    // zero wait states: every access completes in its first access cycle
    assign PREADY = 1'b1;

    always @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            PRDATA  <= 32'h0;
            PSLVERR <= 1'b0;
        end else begin
            PRDATA  <= 32'h0;
            PSLVERR <= 1'b0;
            if (PSEL & ~PENABLE) begin
                PRDATA  <= PWRITE ? 32'h0 : rd_mux;
                PSLVERR <= ~mapped;
            end
        end
    end

    // ----------------------------------------
    // control and enable registers
    // ----------------------------------------
    always @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            ctrl_q   <= `RCFF_CTRL_RST;
            enable_q <= `RCFF_EN_RST;
        end else if (wr & mapped) begin
            if (PADDR == `RCFF_ADDR_CTRL) begin
                ctrl_q <= PWDATA & `RCFF_CTRL_MASKW;
            end
            // software should clear a bit here before editing that filter
            if (PADDR == `RCFF_ADDR_ENABLE) begin
                enable_q <= PWDATA[10:0];
            end
        end
    end

    // ----------------------------------------
    // pattern and mask store
    // ----------------------------------------
    always @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            for (k = 0; k < `RCFF_NUM_ORD; k = k + 1) begin
                pat_q[k] <= `RCFF_ORD_PAT_RST;
                msk_q[k] <= `RCFF_ORD_MSK_RST;
            end
            pat_q[8]  <= `RCFF_PTP_PAT_RST;
            msk_q[8]  <= `RCFF_PTP_MSK_RST;
            pat_q[9]  <= `RCFF_SRA_PAT_RST;
            msk_q[9]  <= `RCFF_SR_MSK_RST;
            pat_q[10] <= `RCFF_SRB_PAT_RST;
            msk_q[10] <= `RCFF_SR_MSK_RST;
        end else if (wr & aligned & sel_ok) begin
            if (in_pat) begin
                pat_q[sel_idx][word_bit +: 32] <= PWDATA;
            end
            if (in_msk) begin
                msk_q[sel_idx][word_bit +: 32] <= PWDATA;
            end
        end
    end

    // ----------------------------------------
    // receive byte position
    // ----------------------------------------
    always @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            byte_cnt_q <= 7'h00;
        end else if (RX_VALID) begin
            if (RX_LAST) begin
                byte_cnt_q <= 7'h00;
            end else if (byte_cnt_q < `RCFF_WIN_BYTES) begin
                byte_cnt_q <= byte_cnt_q + 7'h01;
            end
        end
    end

    // ----------------------------------------
    // filter engines
    // ----------------------------------------
    wire [10:0]  hit;

    genvar g;
    generate
        for (g = 0; g < `RCFF_NUM_ALL; g = g + 1) begin : g_filt
            rcff_match u_match (
                .clk      (CORE_CLK),
                .rst_n    (RESETN),
                .pattern  (pat_q[g]),
                .mask     (msk_q[g]),
                .enable   (enable_q[g]),
                .byte_idx (byte_cnt_q),
                .data     (RX_DATA),
                .valid    (RX_VALID),
                .last     (RX_LAST),
                .hit      (hit[g])
            );
        end
    endgenerate

    wire         ord_any = |hit[7:0];
    wire         av_any  = hit[9] | hit[10];
    wire         cfg_any = ord_any | av_any | hit[8];
    wire         good_d  = RX_GOOD & (promisc | RX_DA_MATCH | cfg_any);

    // ----------------------------------------
    // output stage
    // ----------------------------------------
    // verdicts load only on a last beat, so they stay put until the next frame ends
    always @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            M_DATA       <= 8'h00;
            M_VALID      <= 1'b0;
            M_LAST       <= 1'b0;
            M_GOOD       <= 1'b0;
            FILTER_TUSER <= 9'h000;
            AV_PASS      <= 1'b0;
            last_hit_q   <= 11'h000;
        end else begin
            M_DATA  <= RX_DATA;
            M_VALID <= RX_VALID;
            M_LAST  <= RX_VALID & RX_LAST;
            if (RX_VALID & RX_LAST) begin
                M_GOOD       <= good_d;
                // promiscuous plays no part in the verdict bus
                FILTER_TUSER <= {ord_any, ~hit[7:0]};
                AV_PASS      <= av_any;
                last_hit_q   <= hit;
            end
        end
    end

    // ----------------------------------------
    // frame statistics
    // ----------------------------------------
    // counters wrap; software reads them often enough
    always @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            pass_cnt_q <= 16'h0000;
            drop_cnt_q <= 16'h0000;
        end else if (RX_VALID & RX_LAST) begin
            if (good_d) begin
                pass_cnt_q <= pass_cnt_q + 16'h0001;
            end else begin
                drop_cnt_q <= drop_cnt_q + 16'h0001;
            end
        end
    end

endmodule // rcff_top

`default_nettype wire

// ### test/rcff_sink.sv
`timescale 1ns/1ps
`default_nettype none
module rcff_sink (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       m_valid,
    input  wire logic       m_last,
    input  wire logic       m_good,
    input  wire logic       av_pass,
    input  wire logic [8:0] tuser,
    output var  logic [8:0] s_tuser,
    output var  logic       s_good,
    output var  logic       s_av,
    output var  logic [7:0] s_cnt
);
    // ----------------------------------------
    // frame-end capture, as a priority fifo would
    // ----------------------------------------
    // no back-pressure: verdicts are taken only with the last beat
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_tuser <= 9'h0;
            s_good  <= 1'b0;
            s_av    <= 1'b0;
            s_cnt   <= 8'h0;
        end else if (m_valid && m_last) begin
            s_tuser <= tuser;
            s_good  <= m_good;
            s_av    <= av_pass;
            s_cnt   <= s_cnt + 8'h1;
        end
    end
endmodule // rcff_sink
`default_nettype wire

// ### test/rcff_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module rcff_top_props (
    input wire logic        CORE_CLK,
    input wire logic        RESETN,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic [7:0]  RX_DATA,
    input wire logic        RX_VALID,
    input wire logic        RX_LAST,
    input wire logic        RX_GOOD,
    input wire logic        RX_DA_MATCH,
    input wire logic [7:0]  M_DATA,
    input wire logic        M_VALID,
    input wire logic        M_LAST,
    input wire logic        M_GOOD,
    input wire logic [8:0]  FILTER_TUSER,
    input wire logic        AV_PASS
);
    // ----------------------------------------
    // stream, verdict and apb properties
    // ----------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);

    a_stream_delay: assert property (
        RX_VALID |=> M_VALID && M_DATA == $past(RX_DATA)) else $error("beat not passed on");
    a_last_follow: assert property (
        RX_VALID && RX_LAST |=> M_LAST) else $error("frame end not passed on");
    a_idle_quiet: assert property (
        !RX_VALID |=> !M_VALID && !M_LAST) else $error("beat out of nothing");
    // verdicts must not wander while the consumer is still inside a frame
    a_verdict_hold: assert property (
        !M_LAST |-> $stable(FILTER_TUSER) && $stable(AV_PASS) && $stable(M_GOOD))
        else $error("verdict changed outside frame end");
    a_catch_all: assert property (
        M_LAST |-> FILTER_TUSER[8] == (FILTER_TUSER[7:0] != 8'hff)) else $error("catch-all wrong");
    a_bad_not_good: assert property (
        M_LAST && !$past(RX_GOOD) |-> !M_GOOD) else $error("bad frame marked good");
    a_good_by_addr: assert property (
        M_LAST && $past(RX_GOOD && RX_DA_MATCH) |-> M_GOOD) else $error("address hit not good");
    a_good_by_filt: assert property (
        M_LAST && $past(RX_GOOD) && FILTER_TUSER[8] |-> M_GOOD) else $error("filter hit not good");
    a_apb_ready: assert property (
        PSEL && PENABLE |-> PREADY) else $error("access not answered");
    a_read_quiet: assert property (
        !(PSEL && PENABLE) |-> PRDATA == 32'h0 && !PSLVERR) else $error("read data outside access");
endmodule // rcff_top_props

bind rcff_top rcff_top_props u_props (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .RX_DATA(RX_DATA),
    .RX_VALID(RX_VALID), .RX_LAST(RX_LAST), .RX_GOOD(RX_GOOD), .RX_DA_MATCH(RX_DA_MATCH),
    .M_DATA(M_DATA), .M_VALID(M_VALID), .M_LAST(M_LAST), .M_GOOD(M_GOOD),
    .FILTER_TUSER(FILTER_TUSER), .AV_PASS(AV_PASS));
`default_nettype wire

// ### test/test_rx_configurable_frame_filter.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcff_consts.vh"
module test_rx_configurable_frame_filter;
    logic        clk, rst_n, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    wire  [31:0] prdata;
    wire         pready, pslverr;
    logic [7:0]  rx_data;
    logic        rx_valid, rx_last, rx_good, rx_da;
    wire  [7:0]  m_data;
    wire         m_valid, m_last, m_good, av_pass, s_good, s_av;
    wire  [8:0]  tuser, s_tuser;
    wire  [7:0]  s_cnt;
    logic [7:0]  fb [0:63];
    int          bad_count, n_tests;

    rcff_top dut (.CORE_CLK(clk), .RESETN(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .RX_DATA(rx_data), .RX_VALID(rx_valid), .RX_LAST(rx_last),
        .RX_GOOD(rx_good), .RX_DA_MATCH(rx_da), .M_DATA(m_data), .M_VALID(m_valid),
        .M_LAST(m_last), .M_GOOD(m_good), .FILTER_TUSER(tuser), .AV_PASS(av_pass));
    rcff_sink u_sink (.clk(clk), .rst_n(rst_n), .m_valid(m_valid), .m_last(m_last),
        .m_good(m_good), .av_pass(av_pass), .tuser(tuser), .s_tuser(s_tuser),
        .s_good(s_good), .s_av(s_av), .s_cnt(s_cnt));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // request held until pready is seen high at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] rd, output logic err);
        @(posedge clk); psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk); penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r; logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r; logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(what, exp, r);
    endtask
    task clr;
        for (int k = 0; k < 64; k++) fb[k] = 8'h00;
    endtask
    task frame(input int len, input logic good, input logic da, input logic [8:0] e_tu,
               input logic e_good, input logic e_av);
        logic [7:0] c0;
        c0 = s_cnt;
        for (int k = 0; k < len; k++) begin
            @(posedge clk); rx_valid <= 1'b1; rx_data <= fb[k]; rx_last <= (k == len - 1);
            rx_good <= good; rx_da <= da;
        end
        @(posedge clk); rx_valid <= 1'b0; rx_last <= 1'b0;
        repeat (2) @(negedge clk);
        chk("frame count", {24'h0, c0 + 8'h1}, {24'h0, s_cnt});
        chk("filter verdict", {23'h0, e_tu}, {23'h0, s_tuser});
        chk("good mark", {31'h0, e_good}, {31'h0, s_good});
        chk("av pass", {31'h0, e_av}, {31'h0, s_av});
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_reset_values;
        logic [31:0] r; logic e;
        rdchk("control", `RCFF_ADDR_CTRL, `RCFF_CTRL_RST);
        rdchk("enables", `RCFF_ADDR_ENABLE, 32'h0000_0700);
        rdchk("pattern w0", `RCFF_ADDR_PAT_LO, 32'hffff_ffff);
        rdchk("pattern w1", 8'h44, 32'h0000_ffff);
        rdchk("mask w1", 8'h84, 32'h0000_ffff);
        rdchk("mask w2", 8'h88, 32'h0);
        wr(`RCFF_ADDR_CTRL, 32'h100);
        rdchk("timing w3", 8'h4c, 32'h0000_f788);
        wr(`RCFF_ADDR_CTRL, 32'h101);
        rdchk("class a w3", 8'h4c, 32'h0260_0081);
        wr(`RCFF_ADDR_CTRL, 32'h102);
        rdchk("class b w3", 8'h4c, 32'h0240_0081);
        rdchk("class b mask", 8'h8c, 32'hffff_ffff);
        wr(`RCFF_ADDR_CTRL, 32'h103);
        rdchk("ignored index", 8'h4c, 32'h0);
        apb(1'b0, 8'h02, 32'h0, r, e);
        chk("unaligned error", 32'h1, {31'h0, e});
    endtask
    task t_ordinary;
        clr();
        for (int k = 0; k < 6; k++) fb[k] = 8'hff;
        wr(`RCFF_ADDR_CTRL, 32'h8000_0000);
        frame(16, 1'b1, 1'b1, 9'h0ff, 1'b1, 1'b0);
        wr(`RCFF_ADDR_ENABLE, 32'h701);
        frame(16, 1'b1, 1'b1, 9'h1fe, 1'b1, 1'b0);
        frame(16, 1'b0, 1'b1, 9'h1fe, 1'b0, 1'b0);
    endtask
    task t_promisc;
        fb[0] = 8'h02;
        wr(`RCFF_ADDR_CTRL, 32'h0);
        frame(16, 1'b1, 1'b0, 9'h0ff, 1'b0, 1'b0);
        wr(`RCFF_ADDR_CTRL, 32'h8000_0000);
        frame(16, 1'b1, 1'b0, 9'h0ff, 1'b1, 1'b0);
        wr(`RCFF_ADDR_CTRL, 32'h0);
        frame(16, 1'b1, 1'b1, 9'h0ff, 1'b1, 1'b0);
        fb[0] = 8'hff;
        frame(16, 1'b1, 1'b0, 9'h1fe, 1'b1, 1'b0);
    endtask
    task t_mask;
        wr(`RCFF_ADDR_ENABLE, 32'h700);
        wr(`RCFF_ADDR_CTRL, 32'h3);
        wr(8'h4c, 32'he000_8100);
        wr(8'h8c, 32'he0ff_ff00);
        wr(`RCFF_ADDR_MSK_LO, 32'h0);
        wr(8'h84, 32'h0);
        wr(8'h7c, 32'ha500_0000);
        wr(`RCFF_ADDR_MSK_HI, 32'hff00_0000);
        wr(`RCFF_ADDR_ENABLE, 32'h708);
        clr();
        fb[12] = 8'h55; fb[13] = 8'h81; fb[15] = 8'hed; fb[63] = 8'ha5;
        frame(64, 1'b1, 1'b1, 9'h1f7, 1'b1, 1'b0);
        fb[15] = 8'h4d;
        frame(64, 1'b1, 1'b1, 9'h0ff, 1'b1, 1'b0);
        fb[15] = 8'hed;
        frame(40, 1'b1, 1'b1, 9'h0ff, 1'b1, 1'b0);
        fb[63] = 8'h25;
        frame(64, 1'b1, 1'b1, 9'h0ff, 1'b1, 1'b0);
    endtask
    task t_av_bank;
        wr(`RCFF_ADDR_CTRL, 32'h102);
        wr(8'h4c, 32'h0230_0081);
        wr(`RCFF_ADDR_CTRL, 32'h103);
        wr(8'h4c, 32'h7777_0081);
        wr(`RCFF_ADDR_CTRL, 32'h102);
        rdchk("class b kept", 8'h4c, 32'h0230_0081);
        wr(`RCFF_ADDR_CTRL, 32'h2);
        rdchk("ordinary 2 w3", 8'h4c, 32'h0);
        clr();
        fb[12] = 8'h81; fb[14] = 8'h60; fb[15] = 8'h02;
        frame(16, 1'b1, 1'b0, 9'h0ff, 1'b1, 1'b1);
        fb[14] = 8'h30;
        frame(16, 1'b1, 1'b0, 9'h0ff, 1'b1, 1'b1);
        fb[14] = 8'h40;
        frame(16, 1'b1, 1'b0, 9'h0ff, 1'b0, 1'b0);
        fb[14] = 8'h60;
        wr(`RCFF_ADDR_ENABLE, 32'h508);
        frame(16, 1'b1, 1'b0, 9'h0ff, 1'b0, 1'b0);
        fb[12] = 8'h88; fb[13] = 8'hf7;
        frame(16, 1'b1, 1'b0, 9'h0ff, 1'b1, 1'b0);
    endtask
    // 12 passed and 4 dropped frames so far; the last one hit only the timing filter
    task t_status;
        logic [31:0] r; logic e;
        rdchk("status", `RCFF_ADDR_STATUS, 32'h0100_02ff);
        wr(`RCFF_ADDR_PASSCNT, 32'h0);
        rdchk("passed count", `RCFF_ADDR_PASSCNT, 32'h0000_000c);
        rdchk("dropped count", `RCFF_ADDR_DROPCNT, 32'h0000_0004);
        apb(1'b0, 8'h14, 32'h0, r, e);
        chk("unmapped error", 32'h1, {31'h0, e});
    endtask

    // ----------------------------------------
    // clock, reset, sequence, watchdog
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0;
        pwdata = 32'h0; rx_data = 8'h0; rx_valid = 1'b0; rx_last = 1'b0; rx_good = 1'b0;
        rx_da = 1'b0; bad_count = 0; n_tests = 0;
        clr();
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_reset_values();
        t_ordinary();
        t_promisc();
        t_mask();
        t_av_bank();
        t_status();
        stop_test();
    end
    // the sequence needs well under a thousand cycles; this leaves ample margin
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        stop_test();
    end
endmodule // test_rx_configurable_frame_filter
`default_nettype wire
